// File: core/midi_host_port.v
/*
 * host port emulation of a legacy intelligent MIDI card: data port at
 * base+0, command/status port at base+1, strap-selected base and reset
 * polarity, external data buffer enable, and a byte handshake toward
 * the embedded core.
 * assumes host pins are synchronous to core_clk_i; the serial MIDI path
 * lives elsewhere and is never gated by this block.
 */
`timescale 1ns/1ps
`include "host_port_map.vh"

// Function
// RULE1: host port decoded at one of four base ranges picked by straps.
// RULE2: host access logic needs no relation to the synth/cpu clock; here host pins must be synchronous to core_clk_i.
// RULE3: device decodes read/write strobes and drives data buffer enable.
// RULE4: host reset polarity follows the reset polarity strap.
// RULE5: emulation may stay inactive; serial MIDI path stays independent.
// RULE6: pass-through mode in full, plus a subset of intelligent commands.
// RULE7: status bit 7 is 0 while a received byte waits, else 1.
// RULE8: status bit 6 is 0 when the next byte or command is accepted.
// RULE9: status bits 5 to 0 always read as ones.
// RULE10: offset 0 carries data both ways, offset 1 command and status.
// RULE11: host writes only when bit 6 is 0, reads data when bit 7 is 0.
module midi_host_port (
    // clock and reset
    input  wire       core_clk_i,
    input  wire       arst_n_i,
    // straps and mode
    input  wire [1:0] base_select_strap_i,
    input  wire       host_reset_polarity_strap_i,
    input  wire       emul_enable_i,
    // host bus
    input  wire       host_reset_i,
    input  wire [9:0] host_addr_i,
    input  wire       host_rd_n_i,
    input  wire       host_wr_n_i,
    input  wire [7:0] host_data_i,
    output reg  [7:0] host_data_o,
    output wire       host_data_oe_o,
    output wire       host_buf_en_n_o,
    // toward the embedded core: bytes from host
    output reg  [7:0] core_rx_byte_o,
    output reg        core_rx_is_cmd_o,
    output reg        core_rx_valid_o,
    input  wire       core_rx_ack_i,
    // toward the host: bytes from core
    input  wire [7:0] core_tx_byte_i,
    input  wire       core_tx_valid_i,
    output wire       core_tx_ready_o,
    // state
    output reg        uart_mode_o,
    output wire       host_reset_active_o
);

    wire       hit;
    wire       rd_end;
    wire       wr_end;
    wire       host_rst;
    reg  [7:0] rx_data_reg;
    reg        rx_full_reg;
    reg  [7:0] stat_byte;
    wire       rx_byte_waiting_n;
    wire       host_write_ready_n;
    wire       acc_rd;
    wire       acc_wr;
    wire       on_data;

    // polarity strap sampled combinationally: it is a static level
    assign host_rst = host_reset_i ^ !host_reset_polarity_strap_i; // RULE4
    assign host_reset_active_o = host_rst;

    host_addr_decode u_decode (
        .host_addr_i         (host_addr_i),
        .emul_enable_i       (emul_enable_i),
        .base_select_strap_i (base_select_strap_i),
        .hit_o               (hit)
    );

    host_strobe_edge u_rd_edge (
        .core_clk_i  (core_clk_i),
        .arst_n_i    (arst_n_i),
        .strobe_n_i  (host_rd_n_i),
        .end_pulse_o (rd_end)
    );

    host_strobe_edge u_wr_edge (
        .core_clk_i  (core_clk_i),
        .arst_n_i    (arst_n_i),
        .strobe_n_i  (host_wr_n_i),
        .end_pulse_o (wr_end)
    );

    // address must be held through the strobe's rising edge
    assign on_data = (host_addr_i[0] == `OFS_DATA); // RULE10
    assign acc_rd  = rd_end && hit; // RULE2
    assign acc_wr  = wr_end && hit;

    // the device drives the data bus during its reads and enables the buffer on reads and writes
    assign host_data_oe_o  = hit && !host_rd_n_i; // RULE3
    assign host_buf_en_n_o = !(hit && (!host_rd_n_i || !host_wr_n_i)); // RULE3

    assign rx_byte_waiting_n  = !rx_full_reg; // RULE7
    // not ready while a previous byte is still unclaimed by the core
    assign host_write_ready_n = core_rx_valid_o; // RULE8
    assign core_tx_ready_o    = !rx_full_reg && !host_rst;

    always @* begin
        stat_byte = {rx_byte_waiting_n, host_write_ready_n, `STAT_ONES}; // RULE9
    end

    // read data re-registered every cycle from the port selected by a[0]
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            host_data_o <= `BYTE_RST;
        end else if (on_data) begin
            host_data_o <= rx_data_reg; // RULE10
        end else begin
            host_data_o <= stat_byte; // RULE7
        end
    end

    // bytes toward the host; a fresh core byte wins over the host read
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rx_data_reg <= `BYTE_RST;
            rx_full_reg <= `FLAG_EMPTY;
        end else if (host_rst) begin
            rx_data_reg <= `BYTE_RST;
            rx_full_reg <= `FLAG_EMPTY;
        end else if (acc_wr && !on_data &&
                     (host_data_i == `CMD_RESET ||
                      host_data_i == `CMD_UART_MODE) &&
                     !host_write_ready_n) begin
            // mode commands are acknowledged locally
            rx_data_reg <= `CMD_ACK; // RULE6
            rx_full_reg <= 1'b1;
        end else if (core_tx_valid_i && !rx_full_reg) begin
            rx_data_reg <= core_tx_byte_i;
            rx_full_reg <= 1'b1;
        end else if (acc_rd && on_data) begin
            rx_full_reg <= `FLAG_EMPTY; // RULE10
        end
    end

    // bytes from host toward the core; writes while busy are dropped
    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            core_rx_byte_o   <= `BYTE_RST;
            core_rx_is_cmd_o <= 1'b0;
            core_rx_valid_o  <= 1'b0;
            uart_mode_o      <= 1'b0;
        end else if (host_rst) begin
            core_rx_valid_o  <= 1'b0;
            uart_mode_o      <= 1'b0;
        end else begin
            if (core_rx_ack_i) begin
                core_rx_valid_o <= 1'b0;
            end
            if (acc_wr && !host_write_ready_n) begin
                if (!on_data && host_data_i == `CMD_UART_MODE) begin
                    uart_mode_o <= 1'b1; // RULE6
                end else if (!on_data && host_data_i == `CMD_RESET) begin
                    uart_mode_o <= 1'b0; // RULE6
                end else if (!on_data && uart_mode_o) begin
                    // pass-through mode ignores other commands
                    uart_mode_o <= 1'b1;
                end else begin
                    // other intelligent commands go to firmware
                    core_rx_byte_o   <= host_data_i; // RULE10
                    core_rx_is_cmd_o <= !on_data;
                    core_rx_valid_o  <= 1'b1;
                end
            end
        end
    end

endmodule // midi_host_port

// File: pkg/host_port_map.vh
/*
 * constants for the host port emulation: base ranges, offsets, status
 * layout and internal handshake encodings.
 * assumes inclusion by bare name from the design files.
 */
`ifndef HOST_PORT_MAP_VH
`define HOST_PORT_MAP_VH

// base address ranges selected by the two straps (host a[9:1])
`define BASE_SEL0          9'h0_198
`define BASE_SEL1          9'h0_1A8
`define BASE_SEL2          9'h0_1B8
`define BASE_SEL3          9'h0_168
// port offsets (host a[0])
`define OFS_DATA           1'h0
`define OFS_CMD_STAT       1'h1
// status layout
`define STAT_RX_BIT        7
`define STAT_TX_BIT        6
`define STAT_ONES          6'h3F
// reset values
`define BYTE_RST           8'h00
`define FLAG_EMPTY         1'h0
// acknowledge byte that this block returns itself after a mode command
`define CMD_ACK            8'hFE
// pass-through mode entry command and the reset command that leaves it
`define CMD_UART_MODE      8'h3F
`define CMD_RESET          8'hFF

`endif

// File: core/host_addr_decode.v
/*
 * host address decoder: matches the 10-bit host address against one of
 * four base ranges chosen by straps.
 * assumes the straps are stable during operation.
 */
`timescale 1ns/1ps
`include "host_port_map.vh"

module host_addr_decode (
    // host address
    input  wire [9:0] host_addr_i,
    input  wire       emul_enable_i,
    // straps
    input  wire [1:0] base_select_strap_i,
    // result
    output reg        hit_o
);

    reg [8:0] base_sel;

    always @* begin
        case (base_select_strap_i) // RULE1
            2'h0:    base_sel = `BASE_SEL0;
            2'h1:    base_sel = `BASE_SEL1;
            2'h2:    base_sel = `BASE_SEL2;
            default: base_sel = `BASE_SEL3;
        endcase
        // disabled emulation never claims the bus
        hit_o = emul_enable_i && (host_addr_i[9:1] == base_sel); // RULE5
    end

endmodule // host_addr_decode

// File: core/host_strobe_edge.v
/*
 * strobe edge detector: one-cycle pulse when an active-low host strobe
 * ends, so each access acts once however long it is held.
 * assumes strobes are synchronous to the core clock.
 */
`timescale 1ns/1ps

module host_strobe_edge (
    // clock and reset
    input  wire core_clk_i,
    input  wire arst_n_i,
    // strobe
    input  wire strobe_n_i,
    output wire end_pulse_o
);

    reg strobe_prev_reg;

    always @(posedge core_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            strobe_prev_reg <= 1'b1;
        end else begin
            strobe_prev_reg <= strobe_n_i;
        end
    end

    assign end_pulse_o = strobe_n_i && !strobe_prev_reg;

endmodule // host_strobe_edge

// File: verif/midi_port_sva.sv
/* checker for the host port: decode, strobes, status, byte handshake.
   assumes it is bound to midi_host_port. */
`timescale 1ns/1ps
`include "host_port_map.vh"
module midi_port_sva (
    input wire       core_clk_i, arst_n_i, emul_enable_i, host_reset_i,
    input wire       host_reset_polarity_strap_i, host_reset_active_o,
    input wire [1:0] base_select_strap_i,
    input wire [9:0] host_addr_i,
    input wire       host_rd_n_i, host_wr_n_i, host_data_oe_o,
    input wire       host_buf_en_n_o, core_rx_valid_o, core_rx_ack_i,
    input wire [7:0] host_data_i, host_data_o, core_rx_byte_o
);
    wire [8:0] base = base_select_strap_i[1] ?
        (base_select_strap_i[0] ? `BASE_SEL3 : `BASE_SEL2) :
        (base_select_strap_i[0] ? `BASE_SEL1 : `BASE_SEL0);
    wire hit = emul_enable_i && host_addr_i[9:1] == base;
    wire idle = !core_rx_ack_i && !host_reset_active_o;
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!arst_n_i);
    sequence s_wr_data;
        hit && !host_wr_n_i && !host_addr_i[0] && !core_rx_valid_o && idle
        ##1 hit && host_wr_n_i && !host_addr_i[0] && idle;
    endsequence
    a_oe_decode: assert property (
        host_data_oe_o == (hit && !host_rd_n_i)) else $error("oe wrong");
    a_buf_decode: assert property (
        host_buf_en_n_o == !(hit && !(host_rd_n_i && host_wr_n_i)))
        else $error("buffer enable wrong");
    a_reset_pol: assert property (
        host_reset_active_o == (host_reset_i == host_reset_polarity_strap_i))
        else $error("host reset sense wrong");
    a_status_ones: assert property (
        host_addr_i[0] |=> host_data_o[5:0] == 6'h3f)
        else $error("status low bits wrong");
    a_busy_bit: assert property (
        host_addr_i[0] |=> host_data_o[6] == $past(core_rx_valid_o))
        else $error("busy bit wrong");
    a_rx_hold: assert property (
        core_rx_valid_o && idle |=> core_rx_valid_o && $stable(core_rx_byte_o))
        else $error("byte lost while busy");
    a_ack_clear: assert property (
        core_rx_ack_i && core_rx_valid_o |=> !core_rx_valid_o)
        else $error("ack ignored");
    a_data_write: assert property (
        s_wr_data |=> core_rx_valid_o && core_rx_byte_o == $past(host_data_i))
        else $error("data write lost");
endmodule // midi_port_sva
bind midi_host_port midi_port_sva sva_u (.*);

// File: verif/host_bus_model.sv
/* host bus model: single-byte reads and writes with active-low strobes.
   assumes the core clock is the host timing reference. */
`timescale 1ns/1ps
module host_bus_model (
    input  wire       core_clk_i,
    input  wire [7:0] host_data_o,
    output reg  [9:0] addr_o = 10'h000,
    output reg  [7:0] wdata_o = 8'h00,
    output reg        rd_n_o = 1'b1,
    output reg        wr_n_o = 1'b1
);
    task wr(input [9:0] a, input [7:0] d);
    begin
        @(negedge core_clk_i);
        addr_o = a;
        wdata_o = d;
        wr_n_o = 0;
        @(negedge core_clk_i);
        wr_n_o = 1;
        @(negedge core_clk_i);
        // released bus: never leave the old byte showing
        wdata_o = ~d;
        @(negedge core_clk_i);
    end
    endtask
    task rd(input [9:0] a, output [7:0] d);
    begin
        @(negedge core_clk_i);
        addr_o = a;
        rd_n_o = 0;
        repeat (2) @(negedge core_clk_i);
        d = host_data_o;
        rd_n_o = 1;
        repeat (2) @(negedge core_clk_i);
    end
    endtask
endmodule // host_bus_model

// File: verif/test_midi_host_port.sv
/* bench for midi_host_port: host side through the bus model, core side
   driven here. assumes the checker is bound from its own file. */
`timescale 1ns/1ps
module test_midi_host_port;
    reg        core_clk_i = 0, arst_n_i = 0, emul_enable_i = 1;
    reg        host_reset_i = 0, host_reset_polarity_strap_i = 1;
    reg  [1:0] base_select_strap_i = 0;
    reg  [7:0] core_tx_byte_i = 0;
    reg        core_tx_valid_i = 0, core_rx_ack_i = 0;
    wire [9:0] host_addr_i;
    wire [7:0] host_data_i, host_data_o, core_rx_byte_o;
    wire       host_rd_n_i, host_wr_n_i, host_data_oe_o, host_buf_en_n_o;
    wire       core_rx_is_cmd_o, core_rx_valid_o, core_tx_ready_o;
    wire       uart_mode_o, host_reset_active_o;
    integer    n_mismatch = 0, comparisons = 0, seed = 32'h080d21af, i;
    reg  [7:0] d, got;
    reg  [9:0] base;
    always #25 core_clk_i = ~core_clk_i;
    midi_host_port dut_u (.*);
    host_bus_model host_u (.core_clk_i(core_clk_i), .host_data_o(host_data_o),
        .addr_o(host_addr_i), .wdata_o(host_data_i),
        .rd_n_o(host_rd_n_i), .wr_n_o(host_wr_n_i));
    function [7:0] stat(input waiting, input busy);
        stat = {~waiting, busy, 6'h3f};
    endfunction
    task check(input [7:0] g, input [7:0] e);
    begin
        comparisons = comparisons + 1;
        if (g !== e) begin
            n_mismatch = n_mismatch + 1;
            $display("ERROR %0t: got %h want %h", $time, g, e);
        end
    end
    endtask
    task final_report;
    begin
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    end
    endtask
    task ack;
    begin
        core_rx_ack_i = 1;
        @(negedge core_clk_i);
        core_rx_ack_i = 0;
    end
    endtask
    initial begin
        #400000;
        n_mismatch = n_mismatch + 1;
        final_report;
    end
    initial begin
        repeat (4) @(negedge core_clk_i);
        arst_n_i = 1;
        for (i = 0; i < 4; i = i + 1) begin
            {host_reset_polarity_strap_i, host_reset_i} = i;
            #1 check(host_reset_active_o, i[1] == i[0]);
        end
        host_reset_i = 0;
        for (i = 0; i < 4; i = i + 1) begin
            base_select_strap_i = i;
            base = i == 0 ? 10'h330 : i == 1 ? 10'h350 :
                   i == 2 ? 10'h370 : 10'h2d0;
            d = $random(seed);
            host_u.rd(base + 1, got); check(got, stat(0, 0));
            host_u.wr(base ^ 10'h100, d); check(core_rx_valid_o, 0);
            host_u.wr(base, d); check(core_rx_byte_o, d);
            host_u.rd(base + 1, got); check(got, stat(0, 1));
            ack;
            check(core_tx_ready_o, 1);
            core_tx_byte_i = $random(seed);
            core_tx_valid_i = 1;
            @(negedge core_clk_i);
            core_tx_valid_i = 0;
            host_u.rd(base + 1, got); check(got, stat(1, 0));
            host_u.rd(base, got); check(got, core_tx_byte_i);
            host_u.rd(base + 1, got); check(got, stat(0, 0));
        end
        host_u.wr(base + 1, 8'h10); check(core_rx_is_cmd_o, 1);
        ack;
        host_u.wr(base + 1, 8'h3f); check(uart_mode_o, 1);
        host_u.rd(base, got); check(got, 8'hfe);
        host_u.wr(base + 1, 8'h10); check(core_rx_valid_o, 0);
        emul_enable_i = 0;
        host_u.wr(base, d); check(core_rx_valid_o, 0);
        final_report;
    end
endmodule // test_midi_host_port
